//--- core/isp_defs.vh
// Constants and timing counts for the serial programming port
// Contract
// - Flash pages of 32 words, low bits index
// - EEPROM pages of four bytes, two low bits
// - Refuse program and erase before enable accepted
// - Sample MOSI on rise, shift MISO on fall
// - EEPROM byte write erases target automatically
// - Chip erase sets flash and EEPROM to FF
// - Echo second enable byte during third byte
// - Page buffer loaded bytewise, low before high
// - Write-page commits buffer to selected page
// - EEPROM page write alters only loaded bytes
// - Enable is AC 53, bytes three, four ignored
// - Chip erase is AC then 100 prefix
// - Read flash returns chosen byte in byte four
// - Load page stores data into page buffer
// - Write page opcode 4C, page in bytes two-three
// - Read EEPROM returns addressed byte in byte four
// - Write EEPROM stores data at address
// - Busy poll F0 returns busy in last bit
`ifndef ISP_DEFS_VH
`define ISP_DEFS_VH

`define SYS_CLK_MHZ 25
`define FLASH_WRITE_WAIT_US 4500
`define EEPROM_WRITE_WAIT_US 4000
`define ERASE_WAIT_US 4000
`define WAIT_CNT_W 24

`define FLASH_WORDS 2048
`define FLASH_ADDR_W 11
`define PAGE_WORDS 32
`define PAGE_INDEX_W 5
`define PAGE_FIELD_W 6
`define EEPROM_BYTES 256
`define EEPROM_ADDR_W 8
`define EE_PAGE_BYTES 4

`define OP_PROG_ENABLE 8'hAC
`define ENABLE_SECOND 8'h53
`define ERASE_SECOND_TOP 3'h4
`define OP_READ_FLASH_TOP 4'h2
`define OP_LOAD_FLASH_TOP 4'h4
`define OP_WRITE_FLASH_PAGE 8'h4C
`define OP_READ_EEPROM 8'hA0
`define OP_WRITE_EEPROM 8'hC0
`define OP_LOAD_EEPROM_PAGE 8'hC1
`define OP_WRITE_EEPROM_PAGE 8'hC2
`define OP_BUSY_POLL 8'hF0
`define ERASED_BYTE 8'hFF
`define ERASED_WORD 16'hFFFF

`define INSTR_W 32
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define PIN_SYNC_RESET 3'h4

`endif

//--- core/pin_sync.v
// Two-flop synchronisers for pins from outside the clock domain
`timescale 1ns/10ps
module pin_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
)(
    input wire sys_clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    stage1[i] <= RESET_VALUE[i];
                    stage2[i] <= RESET_VALUE[i];
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage2;
endmodule

//--- core/instr_fifo.v
// Small FIFO between instruction framing and the memory executor
`timescale 1ns/10ps
module instr_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW = 2
)(
    input wire sys_clk,
    input wire sys_rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire do_push;
    wire do_pop;

    // Extra pointer bit tells full from empty
    assign out_valid = (wr_ptr != rd_ptr);
    assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                mem[wr_ptr[AW-1:0]] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

//--- core/serial_isp_programming.v
// Serial in-system programming port: link framing, memories and write executor
`timescale 1ns/10ps
`include "isp_defs.vh"
module serial_isp_programming #(
    parameter [`WAIT_CNT_W-1:0] FLASH_WAIT_CYCLES = `FLASH_WRITE_WAIT_US * `SYS_CLK_MHZ,
    parameter [`WAIT_CNT_W-1:0] EEPROM_WAIT_CYCLES = `EEPROM_WRITE_WAIT_US * `SYS_CLK_MHZ,
    parameter [`WAIT_CNT_W-1:0] ERASE_WAIT_CYCLES = `ERASE_WAIT_US * `SYS_CLK_MHZ
)(
    input wire sys_clk,
    input wire sys_rst,
    input wire reset_pin_n,
    input wire sck,
    input wire mosi,
    output reg miso,
    output reg miso_oe,
    output reg prog_enabled,
    output reg busy
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ERASE = 4'h2;
    localparam [3:0] ST_COMMIT = 4'h4;
    localparam [3:0] ST_WAIT = 4'h8;

    // Memories; flash and EEPROM contents survive sys_rst like a real array, the page buffers reset
    reg [15:0] flash_mem [0:`FLASH_WORDS-1];
    reg [7:0] ee_mem [0:`EEPROM_BYTES-1];
    wire [15:0] page_buf [0:`PAGE_WORDS-1];
    wire [7:0] ee_buf [0:`EE_PAGE_BYTES-1];
    wire [`EE_PAGE_BYTES-1:0] ee_mask;

    // Synchronised pins
    wire [2:0] pin_s;
    wire reset_pin_s;
    wire sck_s;
    wire mosi_s;
    reg sck_d;
    wire sck_rise;
    wire sck_fall;
    wire link_active;

    // Link state
    reg [31:0] rx_shift;
    reg [4:0] bit_count;
    reg [7:0] tx_shift;
    reg push_valid;
    reg [31:0] push_data;
    wire push_ready;
    wire [31:0] next_rx;
    reg [7:0] read_byte;

    // Executor state
    reg [3:0] state;
    reg [`FLASH_ADDR_W-1:0] idx;
    reg [`PAGE_FIELD_W-1:0] page_sel;
    reg [`WAIT_CNT_W-1:0] wait_cnt;
    wire exec_valid;
    wire exec_ready;
    wire [31:0] exec_data;
    wire busy_now;

    pin_sync #(
        .WIDTH(3),
        .RESET_VALUE(`PIN_SYNC_RESET)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in({reset_pin_n, sck, mosi}),
        .sync_out(pin_s)
    );

    assign reset_pin_s = pin_s[2];
    assign sck_s = pin_s[1];
    assign mosi_s = pin_s[0];
    assign link_active = !reset_pin_s;

    // Edge detect relies on wide phases
    assign sck_rise = sck_s && !sck_d;
    assign sck_fall = !sck_s && sck_d;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            sck_d <= 1'b0;
        end else begin
            sck_d <= sck_s;
        end
    end

    assign next_rx = {rx_shift[30:0], mosi_s};

    // Byte decodes of a finished frame
    wire [7:0] f_b1 = next_rx[31:24];
    wire [7:0] f_b2 = next_rx[23:16];
    wire is_enable = (f_b1 == `OP_PROG_ENABLE) && (f_b2 == `ENABLE_SECOND);
    wire is_erase = (f_b1 == `OP_PROG_ENABLE) && (f_b2[7:5] == `ERASE_SECOND_TOP);
    wire is_load_flash = (f_b1[7:4] == `OP_LOAD_FLASH_TOP) && (f_b1[2:0] == 3'h0);
    wire is_write_kind = is_erase || is_load_flash || (f_b1 == `OP_WRITE_FLASH_PAGE) ||
                         (f_b1 == `OP_WRITE_EEPROM) || (f_b1 == `OP_LOAD_EEPROM_PAGE) ||
                         (f_b1 == `OP_WRITE_EEPROM_PAGE);

    // Byte decodes after three bytes, for the read answer in byte four
    wire [7:0] r_b1 = next_rx[23:16];
    wire [7:0] r_b2 = next_rx[15:8];
    wire [7:0] r_b3 = next_rx[7:0];
    wire [`FLASH_ADDR_W-1:0] r_word = {r_b2[2:0], r_b3};
    wire [15:0] r_flash = flash_mem[r_word];

    always @* begin
        read_byte = r_b3;
        if (prog_enabled) begin
            if ((r_b1[7:4] == `OP_READ_FLASH_TOP) && (r_b1[2:0] == 3'h0)) begin
                read_byte = r_b1[3] ? r_flash[15:8] : r_flash[7:0];
            end else if (r_b1 == `OP_READ_EEPROM) begin
                read_byte = ee_mem[r_b3];
            end else if (r_b1 == `OP_BUSY_POLL) begin
                read_byte = {7'h00, busy_now};
            end
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_shift <= 32'h0000_0000;
            bit_count <= 5'h00;
            tx_shift <= 8'h00;
            miso <= 1'b0;
            miso_oe <= 1'b0;
            prog_enabled <= 1'b0;
            push_valid <= 1'b0;
            push_data <= 32'h0000_0000;
        end else begin
            miso_oe <= link_active;
            push_valid <= 1'b0;
            if (!link_active) begin
                // Reset pin high drops mode and realigns framing
                bit_count <= 5'h00;
                tx_shift <= 8'h00;
                miso <= 1'b0;
                prog_enabled <= 1'b0;
            end else if (sck_rise) begin
                rx_shift <= next_rx;
                bit_count <= bit_count + 5'h01;
                if (bit_count[2:0] == 3'h7) begin
                    if (bit_count[4:3] == 2'h2) begin
                        tx_shift <= read_byte;
                    end else begin
                        tx_shift <= next_rx[7:0];
                    end
                end
                if (bit_count == 5'h1F) begin
                    if (is_enable) begin
                        prog_enabled <= 1'b1;
                    end else if (prog_enabled && is_write_kind && push_ready) begin
                        push_valid <= 1'b1;
                        push_data <= next_rx;
                    end
                end
            end else if (sck_fall) begin
                miso <= tx_shift[7];
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    // A full queue drops the frame; polling keeps a correct programmer below that
    instr_fifo #(
        .WIDTH(`INSTR_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_instr_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(exec_valid),
        .out_ready(exec_ready),
        .out_data(exec_data)
    );

    assign exec_ready = (state == ST_IDLE);
    assign busy_now = !exec_ready || exec_valid || push_valid;

    wire [7:0] e_b1 = exec_data[31:24];
    wire [7:0] e_b2 = exec_data[23:16];
    wire [7:0] e_b3 = exec_data[15:8];
    wire [7:0] e_b4 = exec_data[7:0];
    wire [`PAGE_INDEX_W-1:0] e_word = e_b3[`PAGE_INDEX_W-1:0];
    wire [5:0] e_ee_page = e_b3[7:2];

    integer i;

    // Take strobes for the per-entry buffer logic below
    wire exec_take = exec_valid && exec_ready;
    wire take_load_flash = exec_take && (e_b1[7:4] == `OP_LOAD_FLASH_TOP) && (e_b1[2:0] == 3'h0);
    wire take_load_ee = exec_take && (e_b1 == `OP_LOAD_EEPROM_PAGE);
    wire take_write_ee = exec_take && (e_b1 == `OP_WRITE_EEPROM_PAGE);
    wire commit_step = (state == ST_COMMIT);
    wire [`PAGE_INDEX_W-1:0] commit_slot = idx[`PAGE_INDEX_W-1:0];
    wire [1:0] ee_load_slot = e_b3[1:0];

    // One holding word per page slot; loads only happen while idle, so never during a copy
    genvar w;
    generate
        for (w = 0; w < `PAGE_WORDS; w = w + 1) begin : g_page_word
            localparam [`PAGE_INDEX_W-1:0] SLOT = w;
            reg [15:0] held;
            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    held <= `ERASED_WORD;
                end else if (commit_step && (commit_slot == SLOT)) begin
                    // Copied word returns to erased so a later page starts clean
                    held <= `ERASED_WORD;
                end else if (take_load_flash && (e_word == SLOT)) begin
                    if (e_b1[3]) begin
                        held[15:8] <= e_b4;
                    end else begin
                        held[7:0] <= e_b4;
                    end
                end
            end
            assign page_buf[w] = held;
        end
    endgenerate

    // One byte and one loaded flag per EEPROM page slot
    genvar b;
    generate
        for (b = 0; b < `EE_PAGE_BYTES; b = b + 1) begin : g_ee_slot
            localparam [1:0] SLOT = b;
            reg [7:0] held;
            reg loaded;
            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    held <= `ERASED_BYTE;
                    loaded <= 1'b0;
                end else if (take_write_ee) begin
                    // Mask empties as the page is written
                    loaded <= 1'b0;
                end else if (take_load_ee && (ee_load_slot == SLOT)) begin
                    held <= e_b4;
                    loaded <= 1'b1;
                end
            end
            assign ee_buf[b] = held;
            assign ee_mask[b] = loaded;
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            idx <= 11'h000;
            page_sel <= 6'h00;
            wait_cnt <= 24'h00_0000;
            busy <= 1'b0;
        end else begin
            busy <= busy_now;
            if (wait_cnt != 24'h00_0000) begin
                wait_cnt <= wait_cnt - 24'h00_0001;
            end
            case (state)
                ST_IDLE: begin
                    if (exec_valid) begin
                        if ((e_b1 == `OP_PROG_ENABLE) && (e_b2[7:5] == `ERASE_SECOND_TOP)) begin
                            idx <= 11'h000;
                            wait_cnt <= ERASE_WAIT_CYCLES;
                            state <= ST_ERASE;
                        end else if (e_b1 == `OP_WRITE_FLASH_PAGE) begin
                            page_sel <= {e_b2[2:0], e_b3[7:5]};
                            idx <= 11'h000;
                            wait_cnt <= FLASH_WAIT_CYCLES;
                            state <= ST_COMMIT;
                        end else if (e_b1 == `OP_WRITE_EEPROM) begin
                            ee_mem[e_b3] <= e_b4;
                            wait_cnt <= EEPROM_WAIT_CYCLES;
                            state <= ST_WAIT;
                        end else if (e_b1 == `OP_WRITE_EEPROM_PAGE) begin
                            for (i = 0; i < `EE_PAGE_BYTES; i = i + 1) begin
                                if (ee_mask[i]) begin
                                    ee_mem[{e_ee_page, i[1:0]}] <= ee_buf[i];
                                end
                            end
                            wait_cnt <= EEPROM_WAIT_CYCLES;
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_ERASE: begin
                    flash_mem[idx] <= `ERASED_WORD;
                    if (idx < `EEPROM_BYTES) begin
                        ee_mem[idx[`EEPROM_ADDR_W-1:0]] <= `ERASED_BYTE;
                    end
                    idx <= idx + 11'h001;
                    if (idx == `FLASH_WORDS - 1) begin
                        state <= ST_WAIT;
                    end
                end
                ST_COMMIT: begin
                    flash_mem[{page_sel, idx[`PAGE_INDEX_W-1:0]}] <= page_buf[idx[`PAGE_INDEX_W-1:0]];
                    idx <= idx + 11'h001;
                    if (idx[`PAGE_INDEX_W-1:0] == `PAGE_WORDS - 1) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Self-timed cycle runs from the take, loop time included
                    if (wait_cnt <= 24'h00_0001) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- bench/serial_isp_programming_sva.sv
// Concurrent checks on the serial programming port pins
`timescale 1ns/10ps
`include "isp_defs.vh"
module serial_isp_programming_sva #(
    parameter [`WAIT_CNT_W-1:0] FLASH_WAIT_CYCLES = `FLASH_WRITE_WAIT_US * `SYS_CLK_MHZ,
    parameter [`WAIT_CNT_W-1:0] EEPROM_WAIT_CYCLES = `EEPROM_WRITE_WAIT_US * `SYS_CLK_MHZ,
    parameter [`WAIT_CNT_W-1:0] ERASE_WAIT_CYCLES = `ERASE_WAIT_US * `SYS_CLK_MHZ
)(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic prog_enabled,
    input wire logic busy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    int busy_cnt;
    int busy_max;
    // A full queue of the longest operations bounds any busy stretch
    assign busy_max = 5 * (FLASH_WAIT_CYCLES + EEPROM_WAIT_CYCLES + ERASE_WAIT_CYCLES + 2100);
    always @(posedge sys_clk) begin
        if (sys_rst || !busy) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    a_oe_released: assert property (reset_pin_n [*5] |-> !miso_oe)
        else $error("miso driven while reset pin high");
    a_oe_driven: assert property (!reset_pin_n [*5] |-> miso_oe)
        else $error("miso not driven while reset pin low");
    a_enable_cleared: assert property (reset_pin_n [*5] |-> !prog_enabled)
        else $error("enable kept while reset pin high");
    a_enable_held: assert property (!reset_pin_n [*4] ##0 prog_enabled |=> prog_enabled)
        else $error("enable lost while reset pin low");
    a_busy_needs_enable: assert property ($rose(busy) |-> prog_enabled)
        else $error("operation started without enable");
    a_miso_after_fall: assert property ($changed(miso) |-> !sck && !$past(sck))
        else $error("miso changed outside the low clock phase");
    a_busy_after_frame: assert property ($rose(busy) |-> !sck)
        else $error("operation started inside a clock high phase");
    a_miso_parked: assert property (reset_pin_n [*6] |-> !miso)
        else $error("miso not cleared by reset pin");
    a_busy_bounded: assert property (busy_cnt <= busy_max)
        else $error("busy lasted too long");
endmodule
bind serial_isp_programming serial_isp_programming_sva #(
    .FLASH_WAIT_CYCLES(FLASH_WAIT_CYCLES),
    .EEPROM_WAIT_CYCLES(EEPROM_WAIT_CYCLES),
    .ERASE_WAIT_CYCLES(ERASE_WAIT_CYCLES)
) chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .prog_enabled(prog_enabled), .busy(busy));

//--- bench/isp_prog_model.sv
// Programmer model driving the serial programming link
`timescale 1ns/10ps
module isp_prog_model #(
    parameter int POWER_UP_WAIT_NS = 2000
)(
    output logic sck,
    output logic mosi,
    output logic reset_pin_n,
    input wire logic miso
);
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        reset_pin_n = 1'b0;
    end
    // low 200 ns, high 120 ns, all 32 bits sent
    task automatic xfer(input logic [31:0] f, output logic [31:0] r);
        #13;
        for (int i = 31; i >= 0; i--) begin
            mosi = f[i];
            #200;
            r = {r[30:0], miso};
            sck = 1'b1;
            #120;
            sck = 1'b0;
        end
        // Released line must not keep looking like the last bit
        mosi = ~f[0];
    endtask
    task automatic restart();
        reset_pin_n = 1'b1;
        #400;
        reset_pin_n = 1'b0;
    endtask
    // wait (scaled down), then enable with arbitrary tail bytes
    task automatic enable(output logic [31:0] r);
        #POWER_UP_WAIT_NS;
        xfer(32'hAC53_1234, r);
    endtask
endmodule

//--- bench/serial_isp_programming_tb.sv
// Self-checking bench for the serial programming port
`timescale 1ns/10ps
module serial_isp_programming_tb;
    typedef struct {logic [7:0] addr; logic [7:0] data;} row_t;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    wire sck, mosi, reset_pin_n, miso, miso_oe, prog_enabled, busy;
    logic [31:0] r;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] pg[4] = '{8'h11, 8'h5A, 8'h33, 8'h44};
    row_t rows[8] = '{'{8'h00, 8'h3C}, '{8'hFF, 8'hA5}, '{8'h10, 8'h0F}, '{8'h10, 8'hF0},
        '{8'h20, 8'h11}, '{8'h21, 8'h22}, '{8'h22, 8'h33}, '{8'h23, 8'h44}};
    always #20 sys_clk = ~sys_clk;
    serial_isp_programming #(.FLASH_WAIT_CYCLES(24'h00_0258), .EEPROM_WAIT_CYCLES(24'h00_05DC),
        .ERASE_WAIT_CYCLES(24'h00_0258)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .prog_enabled(prog_enabled), .busy(busy));
    isp_prog_model prog (.sck(sck), .mosi(mosi), .reset_pin_n(reset_pin_n), .miso(miso));
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Frames start just after a clock edge so link edges never meet it
    task automatic cmd(input logic [31:0] f);
        @(posedge sys_clk);
        prog.xfer(f, r);
    endtask
    task automatic rd(input logic [31:0] f, input logic [7:0] exp);
        cmd(f);
        check(r[7:0], exp);
    endtask
    task automatic poll_wait(input logic first_busy);
        int n;
        n = 0;
        cmd(32'hF000_0000);
        if (first_busy) check({7'h00, r[0]}, 8'h01);
        while (r[0] !== 1'b0 && n < 100) begin
            cmd(32'hF000_0000);
            n++;
        end
        check({7'h00, r[0]}, 8'h00);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 70000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1 check({5'h00, miso_oe, prog_enabled, busy}, 8'h00);
        repeat (5) @(posedge sys_clk);
        cmd(32'hAC80_0000);
        cmd(32'hC000_0077);
        repeat (10) @(posedge sys_clk);
        #1 check({5'h00, miso_oe, prog_enabled, busy}, 8'h04);
        @(posedge sys_clk);
        prog.enable(r);
        check(r[15:8], 8'h53);
        repeat (5) @(posedge sys_clk);
        #1 check({7'h00, prog_enabled}, 8'h01);
        cmd(32'hAC80_0000);
        poll_wait(1'b1);
        rd(32'h2807_FF00, 8'hFF);
        rd(32'hA000_0000, 8'hFF);
        foreach (rows[i]) begin
            cmd({16'hC000, rows[i].addr, rows[i].data});
            poll_wait(1'b1);
            rd({16'hA000, rows[i].addr, 8'h00}, rows[i].data);
        end
        cmd(32'hC100_015A);
        cmd(32'hC200_2000);
        poll_wait(1'b1);
        for (int i = 0; i < 4; i++) rd({24'hA0_0020 + 24'(i), 8'h00}, pg[i]);
        cmd(32'h4000_0534);
        cmd(32'h4800_0512);
        cmd(32'h4000_1FA5);
        cmd(32'h4C00_6000);
        repeat (3) @(posedge sys_clk);
        #1 check({7'h00, busy}, 8'h01);
        // Stay off the link until the page write has surely ended
        repeat (700) @(posedge sys_clk);
        poll_wait(1'b0);
        rd(32'h2000_6500, 8'h34);
        rd(32'h2800_6500, 8'h12);
        rd(32'h2000_7F00, 8'hA5);
        rd(32'h2800_7F00, 8'hFF);
        rd(32'h2000_6600, 8'hFF);
        rd(32'h2000_8000, 8'hFF);
        cmd(32'h1234_5678);
        repeat (10) @(posedge sys_clk);
        #1 check({7'h00, busy}, 8'h00);
        rd(32'hA000_0000, 8'h3C);
        // Six writes back to back: one executes, four queue, the last is dropped
        for (int i = 0; i < 6; i++) cmd({24'hC0_0080 + 24'(i), 8'h60 + 8'(i)});
        poll_wait(1'b1);
        rd(32'hA000_8000, 8'h60);
        rd(32'hA000_8400, 8'h64);
        rd(32'hA000_8500, 8'hFF);
        @(posedge sys_clk);
        prog.restart();
        #1 check({7'h00, prog_enabled}, 8'h00);
        cmd(32'hC000_0099);
        @(posedge sys_clk);
        prog.enable(r);
        check(r[15:8], 8'h53);
        rd(32'hA000_0000, 8'h3C);
        give_verdict();
    end
endmodule
